// file: lbt_consts.vh
// constants for the line buffer test-port serial access block
`ifndef LBT_CONSTS_VH
`define LBT_CONSTS_VH
// instruction register width and codes
`define LBT_IR_W 4
`define LBT_IR_BYPASS 4'hF
`define LBT_IR_LOAD_CTRL 4'h2
`define LBT_IR_COUNTER_PEEK 4'h6
`define LBT_IR_FAST_STORE 4'h7
`define LBT_IR_FAST_FETCH 4'h8
`define LBT_IR_FAST_FETCH_Q 4'h9
`define LBT_IR_CAPTURE 4'h5
// control register fields
`define LBT_CTRL_W 8
`define LBT_CTRL_RST 8'h00
`define LBT_CTRL_ID_LO 0
`define LBT_CTRL_ID_HI 2
`define LBT_CTRL_STORE_SEL 3
`define LBT_CTRL_STORE_DIR 4
`define LBT_CTRL_FETCH_SEL 5
`define LBT_CTRL_FETCH_DIR 6
`define LBT_CTRL_OE_SYNC 7
// counter and snapshot layout
`define LBT_CNT_W 16
`define LBT_ADDR_W 13
`define LBT_SNAP_W 32
`define LBT_SNAP_STORE_LO 16
`define LBT_BYTE_W 8
`endif

// file: lbt_sync.v
// two-flop synchroniser for one bit
`timescale 1ns/1ps
module lbt_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire clk_i,
  input wire srst_i,
  input wire d_i,
  output wire q_o
);
  reg s1_r; // first stage, read only by s2_r
  reg s2_r; // settled level
  // plain double register; nothing else looks at the first stage
  always @(posedge clk_i) begin
    if (srst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule

// file: lbt_tap_fsm.v
// standard test access port state machine, advanced by a tck rising-edge enable
`timescale 1ns/1ps
module lbt_tap_fsm (
  input wire clk_i,
  input wire srst_i,
  input wire tck_rise_i,
  input wire tms_i,
  output reg [3:0] state_o
);
  localparam S_RESET = 4'h0;
  localparam S_IDLE = 4'h1;
  localparam S_SEL_DR = 4'h2;
  localparam S_CAP_DR = 4'h3;
  localparam S_SH_DR = 4'h4;
  localparam S_EX1_DR = 4'h5;
  localparam S_PA_DR = 4'h6;
  localparam S_EX2_DR = 4'h7;
  localparam S_UP_DR = 4'h8;
  localparam S_SEL_IR = 4'h9;
  localparam S_CAP_IR = 4'hA;
  localparam S_SH_IR = 4'hB;
  localparam S_EX1_IR = 4'hC;
  localparam S_PA_IR = 4'hD;
  localparam S_EX2_IR = 4'hE;
  localparam S_UP_IR = 4'hF;
  reg [3:0] nxt;
  // next state from tms
  always @* begin
    case (state_o)
      S_RESET: nxt = tms_i ? S_RESET : S_IDLE;
      S_IDLE: nxt = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_DR: nxt = tms_i ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: nxt = tms_i ? S_EX1_DR : S_SH_DR;
      S_SH_DR: nxt = tms_i ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: nxt = tms_i ? S_UP_DR : S_PA_DR;
      S_PA_DR: nxt = tms_i ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: nxt = tms_i ? S_UP_DR : S_SH_DR;
      S_UP_DR: nxt = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_IR: nxt = tms_i ? S_RESET : S_CAP_IR;
      S_CAP_IR: nxt = tms_i ? S_EX1_IR : S_SH_IR;
      S_SH_IR: nxt = tms_i ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: nxt = tms_i ? S_UP_IR : S_PA_IR;
      S_PA_IR: nxt = tms_i ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: nxt = tms_i ? S_UP_IR : S_SH_IR;
      S_UP_IR: nxt = tms_i ? S_SEL_DR : S_IDLE;
      default: nxt = S_RESET;
    endcase
  end
  // state advances only on a tck rising edge
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_o <= S_RESET;
    end else if (tck_rise_i) begin
      state_o <= nxt;
    end
  end
endmodule

// file: lbt_top.v
// line buffer memory with test-port counter peek and fast serial store/fetch paths
`timescale 1ns/1ps
`include "lbt_consts.vh"
// Overview of operation
// - counter peek shifts both counters out
// - peek path never loads the counters
// - read counter low half, write high
// - upper counter bits must match id
// - fast store selects eight bit data-in
// - idle tck writes byte, advances write
// - store shift-out carries sampled data pins
// - fast store floats read data outputs
// - fast fetch selects eight bit data-out
// - idle tck advances read, then loads byte
// - fast fetch drives read outputs per enable pin and id match
// - quiet fetch floats read data outputs
// - control bits 0-2 id, reset zero
// - bit3 store reload, bit4 store direction
// - bit5 fetch reload, bit6 fetch direction
// - bit7 selects synchronous output enable
// - unused port gives power-up configuration
// - undriven tdi and tms read as one
// - load control capture clears control register
module lbt_top #(
  parameter DEPTH = 8192
) (
  input wire clk_i,
  input wire srst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  input wire [7:0] data_in_i,
  input wire store_go_i,
  input wire store_reload_n_i,
  input wire fetch_side_go_i,
  input wire fetch_side_reload_n_i,
  input wire oe_n_i,
  output reg [7:0] read_data_out_o,
  output reg read_data_oe_o
);
  // tap state codes, the same binary codes the state machine module uses;
  // only the states that steer data registers are named here, and a change
  // of encoding in the state machine must be repeated in this list
  localparam S_RESET = 4'h0;
  localparam S_IDLE = 4'h1;
  localparam S_CAP_DR = 4'h3;
  localparam S_SH_DR = 4'h4;
  localparam S_UP_DR = 4'h8;
  localparam S_CAP_IR = 4'hA;
  localparam S_SH_IR = 4'hB;
  localparam S_UP_IR = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  wire tck_s; // tck level in clk domain
  wire tms_s; // tms level
  wire tdi_s; // tdi level
  reg tck_d_r; // previous tck for edge find
  // every pin from the test controller crosses two flops before use; the
  // tck edge finder adds a third stage, so tms and tdi seen at a found
  // rising edge are the levels that stood beside that pin edge
  // limitation: tck must stay high and low for several system clocks
  // tms/tdi reset to one so an idle pin acts as a logic one
  lbt_sync #(.RST_VAL(1'b0)) u_sync_tck (.clk_i(clk_i), .srst_i(srst_i), .d_i(tck_i), .q_o(tck_s));
  lbt_sync #(.RST_VAL(1'b1)) u_sync_tms (.clk_i(clk_i), .srst_i(srst_i), .d_i(tms_i), .q_o(tms_s));
  lbt_sync #(.RST_VAL(1'b1)) u_sync_tdi (.clk_i(clk_i), .srst_i(srst_i), .d_i(tdi_i), .q_o(tdi_s));
  always @(posedge clk_i) begin
    if (srst_i) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end
  wire tck_rise = tck_s & ~tck_d_r; // tap samples here
  wire tck_fall = ~tck_s & tck_d_r; // tdo changes here
  // both strobes last one system clock, so each tck edge acts once

  ////////////////////////////////////////////////////////////////////////////
  // tap controller
  wire [3:0] tap_st; // current tap state
  lbt_tap_fsm u_fsm (.clk_i(clk_i), .srst_i(srst_i), .tck_rise_i(tck_rise), .tms_i(tms_s), .state_o(tap_st));
  // the instruction register updates at the rising edge found in update-ir,
  // one tck later than a textbook port; data scans keep the same one-tck
  // lag, which the controller absorbs by passing through the update state

  reg [`LBT_IR_W-1:0] ir_r; // active instruction
  reg [`LBT_IR_W-1:0] ir_sh_r; // instruction shifter
  // instruction register: capture, shift, update; reset selects bypass
  always @(posedge clk_i) begin
    if (srst_i) begin
      ir_r <= `LBT_IR_BYPASS;
      ir_sh_r <= `LBT_IR_CAPTURE;
    end else if (tck_rise) begin
      case (tap_st)
        S_RESET: ir_r <= `LBT_IR_BYPASS;
        S_CAP_IR: ir_sh_r <= `LBT_IR_CAPTURE;
        S_SH_IR: ir_sh_r <= {tdi_s, ir_sh_r[`LBT_IR_W-1:1]};
        S_UP_IR: ir_r <= ir_sh_r;
        default: ir_r <= ir_r;
      endcase
    end
  end
  wire i_peek = (ir_r == `LBT_IR_COUNTER_PEEK);
  wire i_store = (ir_r == `LBT_IR_FAST_STORE);
  wire i_fetch_q = (ir_r == `LBT_IR_FAST_FETCH_Q);
  wire i_fetch = (ir_r == `LBT_IR_FAST_FETCH) | i_fetch_q; // quiet variant behaves alike
  wire i_ctrl = (ir_r == `LBT_IR_LOAD_CTRL);
  // any code not decoded above leaves the one-bit bypass stage on the path
  // one idle tck cycle, under any instruction; the fast paths gate it
  wire idle_tick = tck_rise & (tap_st == S_IDLE);
  // an idle tick under a fast instruction is the only event that touches
  // the memory or the counters from the test port side

  ////////////////////////////////////////////////////////////////////////////
  // control register
  reg [`LBT_CTRL_W-1:0] ctrl_r; // live control bits
  reg [`LBT_CTRL_W-1:0] ctrl_sh_r; // control shifter
  // capture loads zeros, shift from tdi, update commits; reset is zero
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= `LBT_CTRL_RST;
      ctrl_sh_r <= `LBT_CTRL_RST;
    end else if (tck_rise & i_ctrl) begin
      if (tap_st == S_CAP_DR) begin
        ctrl_sh_r <= `LBT_CTRL_RST;
        ctrl_r <= `LBT_CTRL_RST;
      end else if (tap_st == S_SH_DR) begin
        ctrl_sh_r <= {tdi_s, ctrl_sh_r[`LBT_CTRL_W-1:1]};
      end else if (tap_st == S_UP_DR) begin
        ctrl_r <= ctrl_sh_r;
      end
    end
  end
  wire [2:0] depth_match_id = ctrl_r[`LBT_CTRL_ID_HI:`LBT_CTRL_ID_LO];
  wire store_reload_sel = ctrl_r[`LBT_CTRL_STORE_SEL];
  wire store_count_dir = ctrl_r[`LBT_CTRL_STORE_DIR];
  wire fetch_reload_sel = ctrl_r[`LBT_CTRL_FETCH_SEL];
  wire fetch_count_dir = ctrl_r[`LBT_CTRL_FETCH_DIR];
  wire oe_sync_sel = ctrl_r[`LBT_CTRL_OE_SYNC];
  // the live bits are cleared at capture as well as at reset, so a scan
  // abandoned before update leaves the power-up configuration in force

  ////////////////////////////////////////////////////////////////////////////
  // system-side pin sampling; reload registers are loaded by other logic
  wire store_go_s;
  wire store_rl_n_s;
  wire fetch_go_s;
  wire fetch_rl_n_s;
  wire oe_n_s;
  wire [7:0] din_s;
  // the enable, reload and output-enable pins come from another clock
  // domain; reload and output-enable idle high, so their synchronisers
  // reset to one and no false reload or drive follows a reset
  lbt_sync u_s_sg (.clk_i(clk_i), .srst_i(srst_i), .d_i(store_go_i), .q_o(store_go_s));
  lbt_sync #(.RST_VAL(1'b1)) u_s_sr (.clk_i(clk_i), .srst_i(srst_i), .d_i(store_reload_n_i), .q_o(store_rl_n_s));
  lbt_sync u_s_fg (.clk_i(clk_i), .srst_i(srst_i), .d_i(fetch_side_go_i), .q_o(fetch_go_s));
  lbt_sync #(.RST_VAL(1'b1)) u_s_fr (.clk_i(clk_i), .srst_i(srst_i), .d_i(fetch_side_reload_n_i), .q_o(fetch_rl_n_s));
  lbt_sync #(.RST_VAL(1'b1)) u_s_oe (.clk_i(clk_i), .srst_i(srst_i), .d_i(oe_n_i), .q_o(oe_n_s));
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_din
      lbt_sync u_s_d (.clk_i(clk_i), .srst_i(srst_i), .d_i(data_in_i[gi]), .q_o(din_s[gi]));
    end
  endgenerate
  // reload registers held at zero here; their loading path lies outside this block
  wire [`LBT_CNT_W-1:0] store_reload_val = 16'h0000;
  wire [`LBT_CNT_W-1:0] fetch_reload_val = 16'h0000;
  // with both values zero, reload select still matters when counting down,
  // since clear mode honours the count direction and loads all ones there

  ////////////////////////////////////////////////////////////////////////////
  // address counters and memory
  reg [`LBT_CNT_W-1:0] store_addr_count; // write counter
  reg [`LBT_CNT_W-1:0] fetch_addr_count; // read counter
  reg [7:0] mem_r [0:DEPTH-1]; // line storage
  reg [7:0] din_sh_r; // fast-store data-in shifter
  reg [7:0] dout_sh_r; // fast-fetch data-out shifter
  reg [`LBT_SNAP_W-1:0] peek_sh_r; // counter snapshot shifter
  // the memory has no reset; a fetch from a never-written address returns
  // whatever the array holds there
  wire store_match = (store_addr_count[15:13] == depth_match_id);
  wire fetch_match = (fetch_addr_count[15:13] == depth_match_id);
  wire [`LBT_CNT_W-1:0] store_step = store_count_dir ? store_addr_count - 16'h0001 : store_addr_count + 16'h0001;
  wire [`LBT_CNT_W-1:0] fetch_step = fetch_count_dir ? fetch_addr_count - 16'h0001 : fetch_addr_count + 16'h0001;
  // clear value is all zeros up, all ones down
  wire [`LBT_CNT_W-1:0] store_clr = store_count_dir ? 16'hFFFF : 16'h0000;
  wire [`LBT_CNT_W-1:0] fetch_clr = fetch_count_dir ? 16'hFFFF : 16'h0000;
  // a tick needs the go level seen through its synchroniser; a go pin
  // changed less than one system clock before the idle tck edge may
  // miss that tick, so the controller sets it well ahead
  wire store_tick = i_store & idle_tick & store_go_s;
  wire fetch_tick = i_fetch & idle_tick & fetch_go_s;
  // read target is the counter's next value, since the advance comes first
  wire [`LBT_CNT_W-1:0] fetch_next = fetch_step;
  wire fetch_next_match = (fetch_next[15:13] == depth_match_id);
  // depth match is judged on the address actually read, so a fetch that
  // steps out of this device's range returns zero and leaves outputs off

  // counters: reload pins in normal use, idle tck ticks under fast instructions
  always @(posedge clk_i) begin
    if (srst_i) begin
      store_addr_count <= 16'h0000;
      fetch_addr_count <= 16'h0000;
    end else begin
      // scan bits never reach the counters while the peek path is selected
      if (!store_rl_n_s) begin
        store_addr_count <= store_reload_sel ? store_reload_val : store_clr;
      end else if (store_tick) begin
        store_addr_count <= store_step;
      end
      if (!fetch_rl_n_s) begin
        fetch_addr_count <= fetch_reload_sel ? fetch_reload_val : fetch_clr;
      end else if (fetch_tick) begin
        fetch_addr_count <= fetch_next;
      end
    end
  end

  // memory write at current address before the advance
  // the write uses the counter value before the same edge advances it;
  // a mismatch of the upper bits suppresses the write, not the advance
  always @(posedge clk_i) begin
    if (store_tick & store_match) begin
      mem_r[store_addr_count[`LBT_ADDR_W-1:0]] <= din_sh_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers of the fast paths and the peek path
  // capture loads the pin snapshot and the counter snapshot together; the
  // peek shifter has no path back into the counters, so bits shifted in
  // under the peek instruction are simply lost
  always @(posedge clk_i) begin
    if (srst_i) begin
      din_sh_r <= 8'h00;
      dout_sh_r <= 8'h00;
      peek_sh_r <= 32'h00000000;
    end else if (tck_rise) begin
      if (tap_st == S_CAP_DR) begin
        // pins sampled so they stream out while the new byte enters
        din_sh_r <= {din_s[0], din_s[1], din_s[2], din_s[3], din_s[4], din_s[5], din_s[6], din_s[7]};
        peek_sh_r <= {store_addr_count, fetch_addr_count};
      end else if (tap_st == S_SH_DR) begin
        if (i_store) begin
          din_sh_r <= {tdi_s, din_sh_r[7:1]};
        end
        if (i_fetch) begin
          dout_sh_r <= {tdi_s, dout_sh_r[7:1]};
        end
        if (i_peek) begin
          peek_sh_r <= {tdi_s, peek_sh_r[31:1]};
        end
      end
      if (fetch_tick) begin
        dout_sh_r <= fetch_next_match ? mem_r[fetch_next[`LBT_ADDR_W-1:0]] : 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bypass bit and tdo
  reg bypass_r; // single-stage bypass
  always @(posedge clk_i) begin
    if (srst_i) begin
      bypass_r <= 1'b0;
    end else if (tck_rise & (tap_st == S_CAP_DR)) begin
      // a bypassed device shows a known zero as its first bit
      bypass_r <= 1'b0;
    end else if (tck_rise & (tap_st == S_SH_DR)) begin
      bypass_r <= tdi_s;
    end
  end
  reg tdo_nxt;
  // select which stage faces tdo
  always @* begin
    if (tap_st == S_SH_IR) begin
      tdo_nxt = ir_sh_r[0];
    end else if (i_store) begin
      tdo_nxt = din_sh_r[0];
    end else if (i_fetch) begin
      tdo_nxt = dout_sh_r[0];
    end else if (i_peek) begin
      tdo_nxt = peek_sh_r[0];
    end else if (i_ctrl) begin
      tdo_nxt = ctrl_sh_r[0];
    end else begin
      tdo_nxt = bypass_r;
    end
  end
  // tdo moves on the falling tck edge and drives only while shifting
  // changing on the falling edge gives the controller half a tck period of
  // margin before it samples at the next rising edge
  always @(posedge clk_i) begin
    if (srst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= tdo_nxt;
      tdo_oe_o <= (tap_st == S_SH_DR) | (tap_st == S_SH_IR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel read data outputs
  reg [7:0] rd_data_r; // normal-mode read data
  reg oe_sync_r; // clocked output enable
  // the clocked enable adds one system clock of latency; it is kept for
  // users who must meet setup and hold to the system clock
  // read data changes only on a fetch tick, so it holds while no fast fetch runs
  always @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_r <= 8'h00;
      oe_sync_r <= 1'b0;
    end else begin
      oe_sync_r <= ~oe_n_s;
      if (fetch_tick) begin
        rd_data_r <= fetch_next_match ? mem_r[fetch_next[`LBT_ADDR_W-1:0]] : 8'h00;
      end
    end
  end
  wire oe_now = oe_sync_sel ? oe_sync_r : ~oe_n_s;
  // store and quiet fetch float the read outputs whatever the enable pin
  // says; otherwise the pin and the depth match decide together
  always @(posedge clk_i) begin
    if (srst_i) begin
      read_data_out_o <= 8'h00;
      read_data_oe_o <= 1'b0;
    end else begin
      read_data_out_o <= rd_data_r;
      if (i_store | i_fetch_q) begin
        read_data_oe_o <= 1'b0;
      end else begin
        read_data_oe_o <= oe_now & fetch_match;
      end
    end
  end
endmodule

// file: lbt_top_monitor.sv
// port-level checker for the test-port serial access block
`timescale 1ns/1ps
module lbt_top_monitor (
  input wire clk_i,
  input wire srst_i,
  input wire tck_i,
  input wire oe_n_i,
  input wire tdo_o,
  input wire tdo_oe_o,
  input wire [7:0] read_data_out_o,
  input wire read_data_oe_o
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////
  // reset leaves the parallel outputs floating and quiet
  a_reset_rd_quiet: assert property ($fell(srst_i) |-> !read_data_oe_o && read_data_out_o == 8'h00)
    else $error("read outputs not cleared by reset");
  a_reset_tdo_off: assert property ($fell(srst_i) |-> !tdo_oe_o)
    else $error("serial output enabled straight after reset");
  // the serial side only moves around link clock edges
  a_tdo_quiet_idle: assert property (!tck_i [*8] |-> $stable(tdo_o))
    else $error("serial output moved while link clock stood still");
  a_oe_quiet_idle: assert property (!tck_i [*8] |-> $stable(tdo_oe_o))
    else $error("serial output enable moved while link clock stood still");
  a_tdo_on_low: assert property ($changed(tdo_o) |-> !tck_i)
    else $error("serial output changed while link clock high");
  // fetched byte only lands after a rising link clock edge
  a_rdata_on_tick: assert property ($changed(read_data_out_o) |-> tck_i)
    else $error("read data changed away from a link clock tick");
  // output enable pin gates the parallel outputs
  a_oe_float_gn: assert property (oe_n_i [*6] |-> !read_data_oe_o)
    else $error("read outputs driven with output enable released");
  a_oe_rise_gn: assert property ($rose(read_data_oe_o) |-> !oe_n_i && !$past(oe_n_i))
    else $error("read outputs turned on without output enable");
  ////////////////////////////////////////////////////////////////////////
  c_rd_driven: cover property ($rose(read_data_oe_o));
  c_rd_loaded: cover property ($changed(read_data_out_o));
  c_shift_on: cover property ($rose(tdo_oe_o));
endmodule
bind lbt_top lbt_top_monitor u_mon (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck_i), .oe_n_i(oe_n_i),
  .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .read_data_out_o(read_data_out_o), .read_data_oe_o(read_data_oe_o));

// file: lbt_jtag_host.sv
// test controller model driving the serial link of the line buffer
`timescale 1ns/1ps
module lbt_jtag_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  // link clock stands low between frames, lines rest high
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one 125 ns link clock period; tdo is taken just ahead of the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    #62.5;
    tdo = tdo_i;
    tck_o <= 1'b1;
    #62.5;
    tck_o <= 1'b0;
  endtask
  // from a select state: capture, shift n bits lsb first, update
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = '0;
    tick(1'b0, 1'b1, t);
    tick(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    tick(1'b1, 1'b1, t);
  endtask
  // idle is entered only when asked, so a store is not fired by accident
  task automatic shift_ir(input logic [3:0] code, input logic idle);
    logic t;
    logic [31:0] d;
    tick(1'b1, 1'b1, t);
    shift(4, {28'h0, code}, d);
    if (idle) tick(1'b0, 1'b1, t);
    tick(1'b1, 1'b1, t);
  endtask
  // every data scan ends with exactly one idle cycle
  task automatic shift_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    shift(n, din, dout);
    tick(1'b0, 1'b1, t);
    tick(1'b1, 1'b1, t);
  endtask
  task automatic reset_tap();
    logic t;
    repeat (5) tick(1'b1, 1'b1, t);
    tick(1'b0, 1'b1, t);
    tick(1'b1, 1'b1, t);
  endtask
endmodule

// file: lbt_top_tb_top.sv
// self-checking bench for the test-port serial access block
`timescale 1ns/1ps
`include "lbt_consts.vh"
module lbt_top_tb_top;
  logic clk_i;
  logic srst_i;
  logic tck, tms, tdi;
  wire tdo_o;
  wire tdo_oe_o;
  logic [7:0] data_in_i;
  logic store_go_i, store_reload_n_i, fetch_side_go_i, fetch_side_reload_n_i, oe_n_i;
  wire [7:0] read_data_out_o;
  wire read_data_oe_o;
  logic [31:0] got;
  int bad_count;
  int checks_done;
  logic [7:0] bytes [4] = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
  logic [7:0] pins [4] = '{8'h1E, 8'hC4, 8'h37, 8'h62};
  ////////////////////////////////////////////////////////////////////////
  lbt_top dut (.clk_i(clk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o), .data_in_i(data_in_i), .store_go_i(store_go_i), .store_reload_n_i(store_reload_n_i),
    .fetch_side_go_i(fetch_side_go_i), .fetch_side_reload_n_i(fetch_side_reload_n_i), .oe_n_i(oe_n_i),
    .read_data_out_o(read_data_out_o), .read_data_oe_o(read_data_oe_o));
  lbt_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // store path shifts pin d7 out first
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction
  task automatic set_go(input logic s, input logic f);
    @(posedge clk_i);
    store_go_i <= s;
    fetch_side_go_i <= f;
    repeat (8) @(posedge clk_i);
  endtask
  // new pins settle through the synchroniser before capture
  task automatic store_byte(input int k);
    @(posedge clk_i);
    data_in_i <= pins[k];
    repeat (8) @(posedge clk_i);
    host.shift_dr(8, {24'h0, bytes[k]}, got);
    check(got, {24'h0, rev8(pins[k])});
  endtask
  // reload pins low long enough to pass their synchronisers
  task automatic pulse_reload();
    @(posedge clk_i);
    store_reload_n_i <= 1'b0;
    fetch_side_reload_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    store_reload_n_i <= 1'b1;
    fetch_side_reload_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  // new control bits, then a reload, then both counters read back
  task automatic ctrl_reload_peek(input logic [7:0] c, input logic [31:0] e);
    host.shift_ir(`LBT_IR_LOAD_CTRL, 1'b0);
    host.shift_dr(8, {24'h0, c}, got);
    pulse_reload();
    host.shift_ir(`LBT_IR_COUNTER_PEEK, 1'b0);
    host.shift_dr(32, 32'h0, got);
    check(got, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // hang guard well past the longest expected run
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    srst_i = 1'b1;
    data_in_i = 8'h00;
    store_go_i = 1'b0;
    fetch_side_go_i = 1'b0;
    store_reload_n_i = 1'b1;
    fetch_side_reload_n_i = 1'b1;
    oe_n_i = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    host.reset_tap();
    host.shift_ir(`LBT_IR_LOAD_CTRL, 1'b0);
    host.shift_dr(8, 32'hA1, got);
    check(got, 32'h0);
    host.shift_ir(`LBT_IR_LOAD_CTRL, 1'b0);
    host.shift_dr(8, 32'h0, got);
    check(got, 32'h0);
    pulse_reload();
    set_go(1'b1, 1'b0);
    host.shift_ir(`LBT_IR_FAST_STORE, 1'b0);
    for (int k = 0; k < 3; k++) store_byte(k);
    host.shift_ir(`LBT_IR_COUNTER_PEEK, 1'b0);
    host.shift_dr(32, 32'hFFFF_FFFF, got);
    check(got, 32'h0003_0000);
    host.shift_dr(32, 32'h0, got);
    check(got, 32'h0003_0000);
    set_go(1'b0, 1'b1);
    // the read counter stands at 0, one before the first byte wanted
    host.shift_ir(`LBT_IR_FAST_FETCH, 1'b1);
    check(read_data_out_o, bytes[1]);
    check(read_data_oe_o, 1'b1);
    host.shift_dr(8, 32'h0, got);
    check(got, bytes[1]);
    @(posedge clk_i);
    oe_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(read_data_oe_o, 1'b0);
    oe_n_i <= 1'b0;
    set_go(1'b1, 1'b0);
    host.shift_ir(`LBT_IR_FAST_STORE, 1'b0);
    check(read_data_oe_o, 1'b0);
    store_byte(3);
    set_go(1'b0, 1'b1);
    host.shift_ir(`LBT_IR_FAST_FETCH_Q, 1'b1);
    check(read_data_oe_o, 1'b0);
    host.shift_dr(8, 32'h0, got);
    check(got, bytes[3]);
    host.shift_ir(`LBT_IR_COUNTER_PEEK, 1'b0);
    host.shift_dr(32, 32'h0, got);
    check(got, 32'h0004_0004);
    // nonzero id no longer matches the counters' upper bits
    host.shift_ir(`LBT_IR_LOAD_CTRL, 1'b0);
    host.shift_dr(8, 32'h01, got);
    host.shift_ir(`LBT_IR_FAST_FETCH, 1'b1);
    check(read_data_oe_o, 1'b0);
    // direction and reload-select changes, each followed by a reload before the readback
    ctrl_reload_peek(8'h40, 32'h0000_FFFF);
    ctrl_reload_peek(8'h10, 32'hFFFF_0000);
    ctrl_reload_peek(8'h28, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
